//--- dv/hmd_host_model.sv
// Host side model: drives the mode straps and parallel data beats.
`timescale 1ns/10ps
module hmd_host_model (
  input wire logic mclk,
  output logic fsel,
  output logic fam,
  output logic [2:0] bs,
  output logic [17:0] data,
  output logic stb
);
  initial begin
    fsel = 1'b0;
    fam = 1'b0;
    bs = 3'h0;
    data = 18'h00000;
    stb = 1'b0;
  end

  // Straps change only under reset, except where a scenario means otherwise.
  task straps(input logic f, input logic fa, input logic [2:0] b);
    fsel <= f;
    fam <= fa;
    bs <= b;
  endtask

  // One beat a cycle; portions follow the mode's split.
  task beat(input logic [17:0] d, input logic last);
    stb <= 1'b1;
    data <= d;
    @(posedge mclk);
    if (last) begin
      stb <= 1'b0;
      // Released lines show the inverse so stale data never matches.
      data <= ~d;
    end
  endtask
endmodule

//--- dv/hmd_mode_decoder_tb.sv
// Self-checking bench for the host interface mode decoder.
`timescale 1ns/10ps
module hmd_mode_decoder_tb;
  logic mclk, nrst, rd, wr, fsel, fam, stb, waitreq, pixel_valid;
  logic cmd_sel, i80_sel, m68_sel, mddi_sel, ser_sel, ident, c262, chg;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [2:0] mode_code, bs;
  logic [4:0] bus_width;
  logic [17:0] lane_mask, pixel_data, dl;
  int err_total, check_count;

  hmd_host_model u_hmd_host_model (.mclk(mclk), .fsel(fsel), .fam(fam),
    .bs(bs), .data(dl), .stb(stb));
  hmd_mode_decoder u_hmd_mode_decoder (.mclk(mclk), .nrst(nrst),
    .clk_en(1'b1), .format_select_pin(fsel), .bus_family_select(fam),
    .bus_size_select(bs), .host_data_lines(dl), .host_data_stb(stb),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .mode_code(mode_code),
    .cmd_param_sel(cmd_sel), .i80_sel(i80_sel), .m68_sel(m68_sel),
    .mddi_sel(mddi_sel), .serial_rgb_sel(ser_sel),
    .ident_select_bit(ident), .color_262k(c262), .bus_width(bus_width),
    .lane_mask(lane_mask), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .strap_changed(chg));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (waitreq === 1'b0) break;
    end
    if (k == 20) begin
      err_total++;
      stop_test;
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task start(input logic f, input logic fa, input logic [2:0] b);
    u_hmd_host_model.straps(f, fa, b);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task mode_case(input logic f, input logic fa, input logic [2:0] b);
    logic [2:0] m;
    logic [4:0] w;
    logic p;
    m = !f ? 3'h0 : (b[2:1] == 2'h3) ? 3'h7 : b + 3'h1;
    p = m inside {[1:5]};
    w = (m == 1 || m == 2) ? 5'h10 : (m == 3) ? 5'h12 : p ? 5'h08 : 5'h00;
    start(f, fa, b);
    @(negedge mclk);
    chk("mode_code", {29'h0, m}, {29'h0, mode_code});
    chk("cmd_param_sel", {31'h0, !f}, {31'h0, cmd_sel});
    chk("i80_sel", {31'h0, p && !fa}, {31'h0, i80_sel});
    chk("m68_sel", {31'h0, p && fa}, {31'h0, m68_sel});
    chk("mddi_sel", {31'h0, m == 6}, {31'h0, mddi_sel});
    chk("serial_rgb_sel", {31'h0, m == 7}, {31'h0, ser_sel});
    chk("ident", {31'h0, m == 7 && b[0]}, {31'h0, ident});
    chk("color_262k", {31'h0, m inside {2, 3, 4, 7}},
      {31'h0, c262});
    chk("bus_width", {27'h0, w}, {27'h0, bus_width});
    chk("lane_mask", (w == 5'h10) ? 32'h0FFFF : (w == 5'h08) ? 32'h000FF :
      (m == 3 || m == 7) ? 32'h3FFFF : 32'h0,
      {14'h0, lane_mask});
    @(posedge mclk);
    bus(1'b0, 4'h0, 32'h0);
    chk("status_mode", {29'h0, m}, {29'h0, got[2:0]});
  endtask

  task pixel_case(input logic fa, input logic [2:0] b, input int n,
    input logic [17:0] d0, d1, d2, e);
    int k;
    start(1'b1, fa, b);
    u_hmd_host_model.beat(d0, n == 1);
    if (n > 1) u_hmd_host_model.beat(d1, n == 2);
    if (n > 2) u_hmd_host_model.beat(d2, 1'b1);
    for (k = 0; k < 5; k++) begin
      @(negedge mclk);
      if (pixel_valid === 1'b1) break;
    end
    chk("pixel_valid", 32'h1, {31'h0, pixel_valid});
    chk("pixel_data", {14'h0, e}, {14'h0, pixel_data});
    @(posedge mclk);
    bus(1'b0, 4'hC, 32'h0);
    chk("count", 32'h1, got);
  endtask

  initial begin
    err_total = 0;
    check_count = 0;
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    for (int i = 0; i < 17; i++) begin
      mode_case(i < 16, i[3], i[2:0]);
    end
    pixel_case(0, 3'h0, 1, 18'h307E0, 0, 0, 18'h00FC0);
    pixel_case(1, 3'h1, 2, 18'h3AAA9, 18'h3FFFD, 0, 18'h2AAA5);
    pixel_case(0, 3'h3, 3, 18'h3FFFF, 18'h3FF04, 18'h3FF80,
      18'h3F060);
    pixel_case(1, 3'h4, 2, 18'h3FFF8, 18'h3FF1F, 0, 18'h3F03F);
    pixel_case(0, 3'h2, 1, 18'h2D4B1, 0, 0, 18'h2D4B1);
    u_hmd_host_model.straps(1'b1, 1'b0, 3'h0);
    repeat (3) @(negedge mclk);
    chk("mode_code", 32'h3, {29'h0, mode_code});
    chk("strap_changed", 32'h1, {31'h0, chg});
    @(posedge mclk);
    u_hmd_host_model.straps(1'b1, 1'b0, 3'h2);
    bus(1'b1, 4'h4, 32'h2);
    @(posedge mclk);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, got);
    @(negedge mclk);
    chk("strap_changed", 32'h0, {31'h0, chg});
    // Packing is now disabled, so this beat must not make a pixel.
    @(posedge mclk);
    u_hmd_host_model.beat(18'h3FFFF, 1'b1);
    @(negedge mclk);
    chk("pack_off_valid", 32'h0, {31'h0, pixel_valid});
    @(posedge mclk);
    bus(1'b0, 4'h8, 32'h0);
    chk("pixel_reg", 32'h2D4B1, got);
    start(1'b1, 1'b1, 3'h5);
    u_hmd_host_model.beat(18'h3FFFF, 1'b1);
    @(negedge mclk);
    chk("pixel_valid", 32'h0, {31'h0, pixel_valid});
    stop_test;
  end

  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule

//--- rtl/hmd_mode_decoder.sv
// Host interface mode decoder with strap capture and register slave.
//
// Contract
// [RQ1] The mode is chosen only from the format, family and size straps.
// [RQ2] Format low gives command-parameter mode; high decodes the rest.
// [RQ3] On parallel buses family low is Intel-80 and high is Motorola-68.
// [RQ4] Size 000 is a 16-bit bus, 65K colour, top two lines ignored.
// [RQ5] Size 001 is a 16-bit bus, 262K colour, pixels sent as 16 then 2.
// [RQ6] Size 010 is an 18-bit bus, 262K colour, all lines carry data.
// [RQ7] Size 011 is an 8-bit bus, 262K colour, three 6-bit portions.
// [RQ8] Size 100 is an 8-bit bus, 65K colour, as 5-6-5 portions.
// [RQ9] Size 101 picks the serial MDDI link regardless of family.
// [RQ10] Sizes 11x pick serial control plus RGB; the low bit is an ident.
// [RQ11] The board keeps every mode strap fixed from reset onward.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module hmd_mode_decoder (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic format_select_pin,
  input wire logic bus_family_select,
  input wire logic [2:0] bus_size_select,
  input wire logic [17:0] host_data_lines,
  input wire logic host_data_stb,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [2:0] mode_code,
  output logic cmd_param_sel,
  output logic i80_sel,
  output logic m68_sel,
  output logic mddi_sel,
  output logic serial_rgb_sel,
  output logic ident_select_bit,
  output logic color_262k,
  output logic [4:0] bus_width,
  output logic [17:0] lane_mask,
  output logic [17:0] pixel_data,
  output logic pixel_valid,
  output logic strap_changed
);

  hmd_pix_if pix ();

  // ****************************************************************
  // Strap capture and mode decode
  // ****************************************************************
  // The straps are caught once, on the first enabled edge after reset,
  // so later wiggles on the pins cannot retune a running interface.
  logic cap_done_r, cap_done_nxt;
  logic [4:0] straps_r, straps_nxt;
  hmd_pkg::hmd_mode_t mode_r, mode_nxt;
  logic cmd_r, cmd_nxt;
  logic i80_r, i80_nxt;
  logic m68_r, m68_nxt;
  logic mddi_r, mddi_nxt;
  logic srgb_r, srgb_nxt;
  logic ident_r, ident_nxt;
  logic c262_r, c262_nxt;
  logic [4:0] width_r, width_nxt;
  logic [17:0] lanes_r, lanes_nxt;
  logic chg_r, chg_nxt;
  logic [4:0] live;
  hmd_pkg::hmd_mode_t live_mode;
  logic clr_chg;

  assign live = {format_select_pin, bus_family_select, bus_size_select};
  assign live_mode = hmd_pkg::hmd_decode(format_select_pin,
                                         bus_size_select);

  always_comb begin
    cap_done_nxt = cap_done_r;
    straps_nxt = straps_r;
    mode_nxt = mode_r;
    cmd_nxt = cmd_r;
    i80_nxt = i80_r;
    m68_nxt = m68_r;
    mddi_nxt = mddi_r;
    srgb_nxt = srgb_r;
    ident_nxt = ident_r;
    c262_nxt = c262_r;
    width_nxt = width_r;
    lanes_nxt = lanes_r;
    chg_nxt = chg_r;
    if (!cap_done_r) begin
      cap_done_nxt = 1'b1;
      straps_nxt = live; // [RQ1]
      mode_nxt = live_mode; // [RQ1] [RQ2]
      cmd_nxt = !format_select_pin; // [RQ2]
      i80_nxt = hmd_pkg::hmd_is_par(live_mode) &&
                !bus_family_select; // [RQ3]
      m68_nxt = hmd_pkg::hmd_is_par(live_mode) &&
                bus_family_select; // [RQ3]
      mddi_nxt = live_mode == hmd_pkg::HMD_MDDI; // [RQ9]
      srgb_nxt = live_mode == hmd_pkg::HMD_SER_RGB; // [RQ10]
      ident_nxt = live_mode == hmd_pkg::HMD_SER_RGB &&
                  bus_size_select[0]; // [RQ10]
      c262_nxt = hmd_pkg::hmd_is_262k(live_mode);
      width_nxt = hmd_pkg::hmd_width(live_mode); // [RQ4] [RQ6] [RQ7]
      lanes_nxt = hmd_pkg::hmd_lanes(live_mode); // [RQ4] [RQ6] [RQ8]
    end
    // Straps are meant to be static; a change is only reported.
    if (clr_chg) begin
      chg_nxt = 1'b0;
    end
    if (cap_done_r && live != straps_r) begin
      chg_nxt = 1'b1; // [RQ11]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap_done_r <= 1'b0;
      straps_r <= 5'h00;
      mode_r <= hmd_pkg::HMD_CMD_PARAM;
      cmd_r <= 1'b0;
      i80_r <= 1'b0;
      m68_r <= 1'b0;
      mddi_r <= 1'b0;
      srgb_r <= 1'b0;
      ident_r <= 1'b0;
      c262_r <= 1'b0;
      width_r <= hmd_pkg::WIDTH_NONE;
      lanes_r <= hmd_pkg::LANES_NONE;
      chg_r <= 1'b0;
    end else if (clk_en) begin
      cap_done_r <= cap_done_nxt;
      straps_r <= straps_nxt;
      mode_r <= mode_nxt;
      cmd_r <= cmd_nxt;
      i80_r <= i80_nxt;
      m68_r <= m68_nxt;
      mddi_r <= mddi_nxt;
      srgb_r <= srgb_nxt;
      ident_r <= ident_nxt;
      c262_r <= c262_nxt;
      width_r <= width_nxt;
      lanes_r <= lanes_nxt;
      chg_r <= chg_nxt;
    end
  end

  // ****************************************************************
  // Pixel path
  // ****************************************************************
  // Unused upper lines are masked off before packing, so a floating
  // top byte on a narrow bus never leaks into the pixel.
  logic pack_en_r, pack_en_nxt;

  assign pix.beat_stb = host_data_stb && pack_en_r && cap_done_r;
  assign pix.beat_data = host_data_lines & lanes_r; // [RQ4] [RQ8]
  assign pix.mode = mode_r;

  hmd_pixel_packer u_packer (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .p(pix)
  );

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Every access costs exactly one wait cycle while clk_en is high; a low clock enable
  // freezes whichever phase it falls in, the wait or the answer.
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] count_r, count_nxt;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic req;
  logic acc_wr;

  assign req = avs_read || avs_write;
  assign acc_wr = avs_write && !wait_r;
  assign clr_chg = acc_wr && avs_address == hmd_pkg::REG_CTRL &&
                   avs_byteenable[0] &&
                   avs_writedata[hmd_pkg::CTRL_CLR_CHG_BIT];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hmd_pkg::ST_MODE_LSB +: 3] = mode_r;
    status_word[hmd_pkg::ST_FAMILY_BIT] = straps_r[hmd_pkg::STRAP_FAM_POS];
    status_word[hmd_pkg::ST_IDENT_BIT] = ident_r;
    status_word[hmd_pkg::ST_DEPTH_BIT] = c262_r;
    status_word[hmd_pkg::ST_WIDTH_LSB +: 5] = width_r;
    status_word[hmd_pkg::ST_CAPTURED_BIT] = cap_done_r;
    status_word[hmd_pkg::ST_CHANGED_BIT] = chg_r;
    case (avs_address)
      hmd_pkg::REG_STATUS: rd_mux = status_word;
      hmd_pkg::REG_CTRL: rd_mux = {31'h0000_0000, pack_en_r};
      hmd_pkg::REG_PIXEL: rd_mux = {14'h0000, pixel_data};
      hmd_pkg::REG_COUNT: rd_mux = count_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wait_nxt = !(req && wait_r);
    rdata_nxt = rdata_r;
    pack_en_nxt = pack_en_r;
    count_nxt = count_r;
    if (avs_read && wait_r) begin
      rdata_nxt = rd_mux;
    end
    if (acc_wr && avs_address == hmd_pkg::REG_CTRL &&
        avs_byteenable[0]) begin
      pack_en_nxt = avs_writedata[hmd_pkg::CTRL_PACK_EN_BIT];
    end
    if (pix.pix_valid) begin
      count_nxt = count_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      pack_en_r <= hmd_pkg::CTRL_PACK_EN_RST;
      count_r <= hmd_pkg::COUNT_RST;
    end else if (clk_en) begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      pack_en_r <= pack_en_nxt;
      count_r <= count_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign mode_code = mode_r;
  assign cmd_param_sel = cmd_r;
  assign i80_sel = i80_r;
  assign m68_sel = m68_r;
  assign mddi_sel = mddi_r;
  assign serial_rgb_sel = srgb_r;
  assign ident_select_bit = ident_r;
  assign color_262k = c262_r;
  assign bus_width = width_r;
  assign lane_mask = lanes_r;
  assign pixel_data = pix.pix_data;
  assign pixel_valid = pix.pix_valid;
  assign strap_changed = chg_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_req_waiting;
    req && wait_r && clk_en;
  endsequence

  a_mode_from_straps: assert property ( // [RQ1]
    $rose(cap_done_r) |-> mode_r == $past(live_mode))
    else $error("captured mode differs from the strap decode");

  a_mode_held: assert property ( // [RQ1]
    cap_done_r |=> $stable(mode_r) && $stable(lanes_r))
    else $error("mode changed after capture");

  a_cmd_param: assert property ( // [RQ2]
    cap_done_r |-> cmd_r == !straps_r[hmd_pkg::STRAP_FSEL_POS] &&
      (!cmd_r || !(i80_r || m68_r || mddi_r || srgb_r)))
    else $error("format strap not obeyed");

  a_family_sel: assert property ( // [RQ3]
    cap_done_r && hmd_pkg::hmd_is_par(mode_r) |->
      i80_r == !straps_r[hmd_pkg::STRAP_FAM_POS] && i80_r != m68_r)
    else $error("family strobing does not follow the family strap");

  a_sixteen_lanes: assert property ( // [RQ4]
    cap_done_r && mode_r == hmd_pkg::HMD_P16_65K |->
      lanes_r == hmd_pkg::LANES_16 && width_r == hmd_pkg::WIDTH_16 &&
      !c262_r)
    else $error("16-bit 65K mode has wrong lanes or depth");

  a_eighteen_lanes: assert property ( // [RQ6]
    cap_done_r && mode_r == hmd_pkg::HMD_P18_262K |->
      lanes_r == hmd_pkg::LANES_18 && width_r == hmd_pkg::WIDTH_18)
    else $error("18-bit mode does not use all lines");

  a_eight_upper_idle: assert property ( // [RQ8]
    pix.beat_stb && width_r == hmd_pkg::WIDTH_8 |->
      pix.beat_data[17:8] == 10'h000)
    else $error("upper lines leak on an 8-bit bus");

  a_mddi_any_family: assert property ( // [RQ9]
    cap_done_r && straps_r[hmd_pkg::STRAP_FSEL_POS] &&
      straps_r[2:0] == hmd_pkg::BS_MDDI |->
      mddi_r && !i80_r && !m68_r && lanes_r == hmd_pkg::LANES_NONE)
    else $error("MDDI not chosen for its size code");

  a_serial_ident: assert property ( // [RQ10]
    cap_done_r && srgb_r |->
      ident_r == straps_r[0] && mode_r == hmd_pkg::HMD_SER_RGB)
    else $error("ident bit not routed in serial RGB mode");

  a_bus_answer: assert property (
    s_req_waiting |=> !wait_r ##1 (wait_r || !$past(clk_en)))
    else $error("bus answer is not a single wait cycle");

endmodule

//--- rtl/hmd_pix_if.sv
// Beat and pixel carrier between the mode decoder and the pixel packer.
`timescale 1ns/10ps
interface hmd_pix_if;
  logic beat_stb;
  logic [17:0] beat_data;
  hmd_pkg::hmd_mode_t mode;
  logic pix_valid;
  logic [17:0] pix_data;

  modport src (output beat_stb, output beat_data, output mode,
               input pix_valid, input pix_data);
  modport pack (input beat_stb, input beat_data, input mode,
                output pix_valid, output pix_data);
endinterface

//--- rtl/hmd_pixel_packer.sv
// Gathers host data beats into 18-bit pixels according to the bus mode.
`timescale 1ns/10ps
module hmd_pixel_packer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  hmd_pix_if.pack p
);

  hmd_pkg::hmd_beat_t beat_r, beat_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic pv_r, pv_nxt;
  logic [17:0] pd_r, pd_nxt;
  logic acc;

  assign acc = p.beat_stb && clk_en;
  assign p.pix_valid = pv_r;
  assign p.pix_data = pd_r;

  // ****************************************************************
  // Beat assembly
  // ****************************************************************
  always_comb begin
    beat_nxt = beat_r;
    hold_nxt = hold_r;
    pv_nxt = 1'b0;
    pd_nxt = pd_r;
    if (p.beat_stb) begin
      case (p.mode)
        hmd_pkg::HMD_P16_65K: begin
          pv_nxt = 1'b1;
          pd_nxt = hmd_pkg::hmd_exp565(p.beat_data[15:0]); // [RQ4]
        end
        hmd_pkg::HMD_P16_262K: begin
          if (beat_r == hmd_pkg::HMD_BEAT0) begin
            hold_nxt = p.beat_data[15:0]; // [RQ5]
            beat_nxt = hmd_pkg::HMD_BEAT1;
          end else begin
            pv_nxt = 1'b1;
            pd_nxt = {hold_r, p.beat_data[1:0]}; // [RQ5]
            beat_nxt = hmd_pkg::HMD_BEAT0;
          end
        end
        hmd_pkg::HMD_P18_262K: begin
          pv_nxt = 1'b1;
          pd_nxt = p.beat_data; // [RQ6]
        end
        hmd_pkg::HMD_P8_262K: begin
          unique case (beat_r)
            hmd_pkg::HMD_BEAT0: begin
              hold_nxt[15:10] = p.beat_data[7:2]; // [RQ7]
              beat_nxt = hmd_pkg::HMD_BEAT1;
            end
            hmd_pkg::HMD_BEAT1: begin
              hold_nxt[9:4] = p.beat_data[7:2]; // [RQ7]
              beat_nxt = hmd_pkg::HMD_BEAT2;
            end
            hmd_pkg::HMD_BEAT2: begin
              pv_nxt = 1'b1;
              pd_nxt = {hold_r[15:4], p.beat_data[7:2]}; // [RQ7]
              beat_nxt = hmd_pkg::HMD_BEAT0;
            end
            default: beat_nxt = hmd_pkg::HMD_BEAT0;
          endcase
        end
        hmd_pkg::HMD_P8_65K: begin
          if (beat_r == hmd_pkg::HMD_BEAT0) begin
            hold_nxt[15:8] = p.beat_data[7:0]; // [RQ8]
            beat_nxt = hmd_pkg::HMD_BEAT1;
          end else begin
            pv_nxt = 1'b1;
            pd_nxt = hmd_pkg::hmd_exp565({hold_r[15:8],
                                          p.beat_data[7:0]}); // [RQ8]
            beat_nxt = hmd_pkg::HMD_BEAT0;
          end
        end
        default: beat_nxt = hmd_pkg::HMD_BEAT0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      beat_r <= hmd_pkg::HMD_BEAT0;
      hold_r <= 16'h0000;
      pv_r <= 1'b0;
      pd_r <= 18'h00000;
    end else if (clk_en) begin
      beat_r <= beat_nxt;
      hold_r <= hold_nxt;
      pv_r <= pv_nxt;
      pd_r <= pd_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_p8_last;
    acc && p.mode == hmd_pkg::HMD_P8_262K &&
      beat_r == hmd_pkg::HMD_BEAT2;
  endsequence

  sequence s_p16_tail;
    acc && p.mode == hmd_pkg::HMD_P16_262K &&
      beat_r == hmd_pkg::HMD_BEAT1;
  endsequence

  a_split_sixteen_two: assert property ( // [RQ5]
    s_p16_tail |=> pv_r && pd_r[1:0] == $past(p.beat_data[1:0]))
    else $error("16+2 pixel tail not taken from the second beat");

  a_three_six_last: assert property ( // [RQ7]
    s_p8_last |=> pv_r && pd_r[5:0] == $past(p.beat_data[7:2]))
    else $error("third six-bit portion did not finish the pixel");

  a_three_six_early: assert property ( // [RQ7]
    acc && p.mode == hmd_pkg::HMD_P8_262K &&
      beat_r != hmd_pkg::HMD_BEAT2 |=> !pv_r)
    else $error("pixel issued before its third portion");

  a_five_six_five: assert property ( // [RQ8]
    acc && p.mode == hmd_pkg::HMD_P8_65K &&
      beat_r == hmd_pkg::HMD_BEAT1
      |=> pv_r && pd_r[5:1] == $past(p.beat_data[4:0]))
    else $error("blue portion of a 5-6-5 pixel misplaced");

endmodule

//--- rtl/hmd_pkg.sv
// Shared constants, types and decode functions for the host mode decoder.
package hmd_pkg;

  // ****************************************************************
  // Interface modes and pixel beat phases
  // ****************************************************************
  typedef enum logic [2:0] {
    HMD_CMD_PARAM,
    HMD_P16_65K,
    HMD_P16_262K,
    HMD_P18_262K,
    HMD_P8_262K,
    HMD_P8_65K,
    HMD_MDDI,
    HMD_SER_RGB
  } hmd_mode_t;

  typedef enum logic [1:0] {
    HMD_BEAT0,
    HMD_BEAT1,
    HMD_BEAT2
  } hmd_beat_t;

  // ****************************************************************
  // Strap codes
  // ****************************************************************
  localparam logic [2:0] BS_P16_65K = 3'h0;
  localparam logic [2:0] BS_P16_262K = 3'h1;
  localparam logic [2:0] BS_P18_262K = 3'h2;
  localparam logic [2:0] BS_P8_262K = 3'h3;
  localparam logic [2:0] BS_P8_65K = 3'h4;
  localparam logic [2:0] BS_MDDI = 3'h5;
  localparam logic [1:0] BS_SER_RGB_HI = 2'h3;
  localparam int STRAP_FSEL_POS = 4;
  localparam int STRAP_FAM_POS = 3;
  localparam int DATA_W = 18;

  // ****************************************************************
  // Lane masks and bus widths
  // ****************************************************************
  localparam logic [17:0] LANES_NONE = 18'h00000;
  localparam logic [17:0] LANES_8 = 18'h000FF;
  localparam logic [17:0] LANES_16 = 18'h0FFFF;
  localparam logic [17:0] LANES_18 = 18'h3FFFF;
  localparam logic [4:0] WIDTH_NONE = 5'h00;
  localparam logic [4:0] WIDTH_8 = 5'h08;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_18 = 5'h12;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_PIXEL = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hC;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FAMILY_BIT = 3;
  localparam int ST_IDENT_BIT = 4;
  localparam int ST_DEPTH_BIT = 5;
  localparam int ST_WIDTH_LSB = 8;
  localparam int ST_CAPTURED_BIT = 16;
  localparam int ST_CHANGED_BIT = 17;
  localparam int CTRL_PACK_EN_BIT = 0;
  localparam int CTRL_CLR_CHG_BIT = 1;
  localparam logic CTRL_PACK_EN_RST = 1'b1;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic hmd_mode_t hmd_decode(input logic fsel,
                                           input logic [2:0] bs);
    hmd_mode_t m;
    m = HMD_CMD_PARAM;
    if (fsel) begin
      if (bs[2:1] == BS_SER_RGB_HI) begin
        m = HMD_SER_RGB;
      end else begin
        case (bs)
          BS_P16_65K: m = HMD_P16_65K;
          BS_P16_262K: m = HMD_P16_262K;
          BS_P18_262K: m = HMD_P18_262K;
          BS_P8_262K: m = HMD_P8_262K;
          BS_P8_65K: m = HMD_P8_65K;
          BS_MDDI: m = HMD_MDDI;
          default: m = HMD_CMD_PARAM;
        endcase
      end
    end
    return m;
  endfunction

  function automatic logic hmd_is_par(input hmd_mode_t m);
    return m inside {HMD_P16_65K, HMD_P16_262K, HMD_P18_262K,
                     HMD_P8_262K, HMD_P8_65K};
  endfunction

  function automatic logic hmd_is_262k(input hmd_mode_t m);
    return m inside {HMD_P16_262K, HMD_P18_262K, HMD_P8_262K,
                     HMD_SER_RGB};
  endfunction

  function automatic logic [17:0] hmd_lanes(input hmd_mode_t m);
    logic [17:0] l;
    l = LANES_NONE;
    if (m inside {HMD_P16_65K, HMD_P16_262K}) begin
      l = LANES_16;
    end else if (m inside {HMD_P18_262K, HMD_SER_RGB}) begin
      l = LANES_18;
    end else if (m inside {HMD_P8_262K, HMD_P8_65K}) begin
      l = LANES_8;
    end
    return l;
  endfunction

  function automatic logic [4:0] hmd_width(input hmd_mode_t m);
    logic [4:0] w;
    w = WIDTH_NONE;
    if (m inside {HMD_P16_65K, HMD_P16_262K}) begin
      w = WIDTH_16;
    end else if (m == HMD_P18_262K) begin
      w = WIDTH_18;
    end else if (m inside {HMD_P8_262K, HMD_P8_65K}) begin
      w = WIDTH_8;
    end
    return w;
  endfunction

  // Five-bit red and blue are widened by repeating their top bit.
  function automatic logic [17:0] hmd_exp565(input logic [15:0] p);
    return {p[15:11], p[15], p[10:5], p[4:0], p[4]};
  endfunction

endpackage
